// ==== trap_pkg.sv ====
/*
  constants, types and register map of the core trap unit.
  assumes one clock (mclk, 25 MHz) and a synchronous active-low reset.
*/
// Behaviour
// - eight trap classes, identifier names the cause
// - system call identifier is instruction immediate
// - no class zero without translation unit
// - synchronous trap precise, taken at once
// - asynchronous traps use trap table, unmaskable
// - synchronous return is faulting instruction pc
// - asynchronous return is next instruction pc
// - trap leaves cpu priority number alone
// - entry is class shifted five, or base
// - identifier written to data register fifteen
// - all permissions, protection set zero
// - entry selects interrupt stack pointer
// - clear call depth, limit set 64
// - interrupts off until handler enables
// - page miss raises class zero, id 0
// - page permission fail raises class zero, id 1
// - privileged instruction misuse raises class one, id 1
// - read outside read ranges, id 2
// - write outside write ranges, id 3
// - pc outside execute ranges, id 4
// - lowest user mode segment 14/15, id 5
// - address zero load/store, id 6
// - protected global register write, id 7
package trap_pkg;

  // ==========================================
  // widths and build options
  localparam int             NUM_RANGES = 4;       // protection ranges
  localparam int             VEC_SHIFT  = 5;       // eight words per entry
  localparam logic           HAS_MMU    = 1'h1;    // translation unit fitted

  // ==========================================
  // trap classes and identifiers
  localparam logic [2:0]     CLASS_MMU      = 3'h0;
  localparam logic [2:0]     CLASS_PROT     = 3'h1;
  localparam logic [2:0]     CLASS_SYSTEM_CALL_INSTRUCTION  = 3'h6;
  localparam logic [7:0]     TIN_PAGE_FILL  = 8'h00;
  localparam logic [7:0]     TIN_PAGE_PROT  = 8'h01;
  localparam logic [7:0]     TIN_PRIVILEGE_VIOLATION_TRAP       = 8'h01;
  localparam logic [7:0]     TIN_RANGE_RD   = 8'h02;
  localparam logic [7:0]     TIN_RANGE_WR   = 8'h03;
  localparam logic [7:0]     TIN_RANGE_EX   = 8'h04;
  localparam logic [7:0]     TIN_PERIPH     = 8'h05;
  localparam logic [7:0]     TIN_NULL       = 8'h06;
  localparam logic [7:0]     TIN_GLOBAL_WR  = 8'h07;

  // ==========================================
  // address and register-number decoding
  localparam int             SEG_LSB        = 28;
  localparam logic [3:0]     SEG_PERIPH_A   = 4'hE;
  localparam logic [3:0]     SEG_PERIPH_B   = 4'hF;
  localparam logic [3:0]     GREG_A         = 4'h0;
  localparam logic [3:0]     GREG_B         = 4'h1;
  localparam logic [3:0]     GREG_C         = 4'h8;
  localparam logic [3:0]     GREG_D         = 4'h9;

  // ==========================================
  // forced state on entry
  localparam logic [1:0]     PRS_INTERRUPT_MAP = 2'h0;
  localparam logic [6:0]     CDC_ENTRY_64      = 7'h00; // counter zero, 64 limit

  // ==========================================
  // register map (byte addresses)
  localparam logic [7:0]     REG_CTRL       = 8'h00;
  localparam logic [7:0]     REG_TRAP_BASE  = 8'h04;
  localparam logic [7:0]     REG_PERM       = 8'h08;
  localparam logic [7:0]     REG_STATUS     = 8'h0C;
  localparam logic [7:0]     REG_RET_PC     = 8'h10;
  localparam logic [7:0]     REG_COUNT      = 8'h14;
  localparam logic [7:0]     REG_RANGE_BASE = 8'h20;
  localparam logic [7:0]     REG_RANGE_END  = 8'h40;
  localparam int             RANGE_IDX_LSB  = 3;   // 8 bytes per range
  localparam int             RANGE_HI_BIT   = 2;   // upper bound at +4
  localparam int             CTRL_MPU_BIT   = 0;
  localparam int             CTRL_MMU_BIT   = 1;
  localparam int             PERM_RD_LSB    = 0;
  localparam int             PERM_WR_LSB    = 4;
  localparam int             PERM_EX_LSB    = 8;
  localparam int             STAT_TIN_LSB   = 8;
  localparam int             STAT_SYNC_BIT  = 16;
  localparam int             STAT_IE_BIT    = 17;
  localparam logic [31:0]    CTRL_RST       = 32'h0000_0000;
  localparam logic [31:0]    BASE_RST       = 32'h0000_0000;
  localparam logic [31:0]    PERM_RST       = 32'h0000_0000;

  // ==========================================
  // types
  typedef enum logic [1:0] {mode_user0, mode_user1, mode_supervisor} mode_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } av_req_t;

  typedef struct packed {
    logic        valid;       // instruction completes this cycle
    logic [31:0] pc;          // its pc, or fetch pc when idle
    logic [31:0] next_pc;     // pc that follows it
    logic [31:0] ea;          // effective data address
    logic        is_load;
    logic        is_store;
    logic        is_load_modify_store_instruction;
    logic        is_swap;
    logic        is_system_call_instruction;
    logic [7:0]  system_call_instruction_imm;
    logic        is_core_wr;
    logic        is_ctx_save;
    logic        is_en_dis;
    logic        is_tlb_op;
    logic        wr_global;
    logic [3:0]  global_idx;
  } instr_t;

  typedef struct packed {
    logic        valid;
    logic [2:0]  cls;
    logic [7:0]  trap_identifier_number;
  } async_t;

  typedef struct packed {
    logic        valid;
    logic        is_sync;
    logic [2:0]  cls;
    logic [7:0]  trap_identifier_number;
    logic [31:0] vector;
    logic [31:0] ret_pc;
    logic        perm_all;
    logic [1:0]  prs;
    logic        stack_is;
    logic [6:0]  cdc;
  } entry_t;

endpackage

// ==== range_match.sv ====
/*
  one protection range compare: lower <= addr < upper.
  assumes the bounds come from registers on the same clock.
*/
`timescale 1ns/1ns
module range_match (
  // range bounds
  input  wire logic [31:0] lower,
  input  wire logic [31:0] upper,
  // probe
  input  wire logic [31:0] addr,
  input  wire logic        enable,
  // result
  output logic             hit
);

  // ==========================================
  // compare
  // an empty range (upper <= lower) never hits
  assign hit = enable & (addr >= lower) & (addr < upper);

endmodule

// ==== cpu_trap_unit.sv ====
/*
  trap unit: detects protection and translation traps, picks one,
  forms the handler entry and the forced processor state.
  assumes the pipeline holds an instruction until it is flushed or
  completes, and drives pc/next_pc every cycle.
*/
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/1ns
module cpu_trap_unit (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                rst_b,
  // register bus
  input  wire trap_pkg::av_req_t   av,
  output logic [31:0]              av_readdata,
  output logic                     av_waitrequest,
  // pipeline
  input  wire trap_pkg::instr_t    instr,
  input  wire trap_pkg::mode_t     mode,
  input  wire logic                global_wr_perm,
  input  wire logic                ie_set,
  input  wire logic                ie_clr,
  output logic                     sync_flush,
  // asynchronous sources
  input  wire trap_pkg::async_t    async_req,
  output logic                     async_ack,
  // translation checks
  input  wire logic                tlb_miss,
  input  wire logic                page_perm_fail,
  // fetch and state update
  output trap_pkg::entry_t         entry,
  output logic                     d15_we,
  output logic [31:0]              d15_data,
  output logic                     int_enable
);

  // ==========================================
  // decode helpers
  // peripheral segments 14 and 15
  function automatic logic is_periph_seg(input logic [31:0] a);
    logic [3:0] s;
    s = a[trap_pkg::SEG_LSB +: 4];
    return (s == trap_pkg::SEG_PERIPH_A) || (s == trap_pkg::SEG_PERIPH_B);
  endfunction

  // write-protected global address registers
  function automatic logic is_prot_greg(input logic [3:0] i);
    return (i == trap_pkg::GREG_A) || (i == trap_pkg::GREG_B) ||
           (i == trap_pkg::GREG_C) || (i == trap_pkg::GREG_D);
  endfunction

  // address lies in the range-bound window
  function automatic logic is_range_addr(input logic [7:0] a);
    return (a >= trap_pkg::REG_RANGE_BASE) && (a < trap_pkg::REG_RANGE_END);
  endfunction

  // byte-lane merge for partial writes
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================
  // software registers
  logic [31:0] ctrl;                                 // protection enables
  logic [31:0] trap_table_base;                      // vector table base
  logic [31:0] perm;                                 // per-range permissions
  logic [31:0] rng_lo [trap_pkg::NUM_RANGES];        // range lower bounds
  logic [31:0] rng_hi [trap_pkg::NUM_RANGES];        // range upper bounds
  logic [31:0] trap_count;                           // traps taken
  logic        rd_done;                              // read answer cycle
  logic        wr_hit;                               // write accepted
  logic [31:0] next_readdata;                        // read mux

  assign wr_hit = av.write;  // writes never wait

  // control, base and permissions
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctrl            <= trap_pkg::CTRL_RST;
      trap_table_base <= trap_pkg::BASE_RST;
      perm            <= trap_pkg::PERM_RST;
    end else if (wr_hit) begin
      case (av.address)
        trap_pkg::REG_CTRL: begin
          ctrl <= be_merge(ctrl, av.writedata, av.byteenable);
        end
        trap_pkg::REG_TRAP_BASE: begin
          trap_table_base <= be_merge(trap_table_base, av.writedata, av.byteenable);
        end
        trap_pkg::REG_PERM: begin
          perm <= be_merge(perm, av.writedata, av.byteenable);
        end
        default: begin
          // read-only or unmapped: ignored
        end
      endcase
    end
  end

  // range bounds
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      for (int r = 0; r < trap_pkg::NUM_RANGES; r++) begin
        rng_lo[r] <= 32'h0000_0000;
        rng_hi[r] <= 32'h0000_0000;
      end
    end else if (wr_hit && is_range_addr(av.address)) begin
      if (av.address[trap_pkg::RANGE_HI_BIT]) begin
        rng_hi[av.address[trap_pkg::RANGE_IDX_LSB +: 2]] <=
          be_merge(rng_hi[av.address[trap_pkg::RANGE_IDX_LSB +: 2]], av.writedata, av.byteenable);
      end else begin
        rng_lo[av.address[trap_pkg::RANGE_IDX_LSB +: 2]] <=
          be_merge(rng_lo[av.address[trap_pkg::RANGE_IDX_LSB +: 2]], av.writedata, av.byteenable);
      end
    end
  end

  // read mux: unmapped reads return zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    case (av.address)
      trap_pkg::REG_CTRL:      next_readdata = ctrl;
      trap_pkg::REG_TRAP_BASE: next_readdata = trap_table_base;
      trap_pkg::REG_PERM:      next_readdata = perm;
      trap_pkg::REG_STATUS: begin
        next_readdata[2:0]                         = entry.cls;
        next_readdata[trap_pkg::STAT_TIN_LSB +: 8] = entry.trap_identifier_number;
        next_readdata[trap_pkg::STAT_SYNC_BIT]     = entry.is_sync;
        next_readdata[trap_pkg::STAT_IE_BIT]       = int_enable;
      end
      trap_pkg::REG_RET_PC:    next_readdata = entry.ret_pc;
      trap_pkg::REG_COUNT:     next_readdata = trap_count;
      default: begin
        if (is_range_addr(av.address)) begin
          next_readdata = av.address[trap_pkg::RANGE_HI_BIT] ?
                          rng_hi[av.address[trap_pkg::RANGE_IDX_LSB +: 2]] :
                          rng_lo[av.address[trap_pkg::RANGE_IDX_LSB +: 2]];
        end
      end
    endcase
  end

  // one wait state per read; data then stands for the release edge
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rd_done     <= 1'h0;
      av_readdata <= 32'h0000_0000;
    end else if (av.read && !rd_done) begin
      rd_done     <= 1'h1;
      av_readdata <= next_readdata;
    end else begin
      rd_done     <= 1'h0;
    end
  end

  assign av_waitrequest = av.read & ~rd_done;

  // ==========================================
  // range checks
  logic [trap_pkg::NUM_RANGES-1:0] dhit;  // data address in range
  logic [trap_pkg::NUM_RANGES-1:0] xhit;  // pc in range

  for (genvar r = 0; r < trap_pkg::NUM_RANGES; r++) begin : g_rng
    range_match u_data (
      .lower  (rng_lo[r]),
      .upper  (rng_hi[r]),
      .addr   (instr.ea),
      .enable (1'h1),
      .hit    (dhit[r])
    );
    range_match u_exec (
      .lower  (rng_lo[r]),
      .upper  (rng_hi[r]),
      .addr   (instr.pc),
      .enable (1'h1),
      .hit    (xhit[r])
    );
  end

  // ==========================================
  // trap conditions
  logic mpu_on;      // range protection enabled
  logic mmu_on;      // translation enabled and fitted
  logic user_any;    // either user mode
  logic user0;       // lowest user mode
  logic mem_op;      // any load or store
  logic rd_op;       // access that reads
  logic wr_op;       // access that writes
  logic c_ex;
  logic c_privilege_violation_trap;
  logic c_fill;
  logic c_pgprot;
  logic c_null;
  logic c_periph;
  logic c_rd;
  logic c_wr;
  logic c_global_register_write_trap;

  assign mpu_on   = ctrl[trap_pkg::CTRL_MPU_BIT];
  // without a translation unit class zero can never fire
  assign mmu_on   = trap_pkg::HAS_MMU & ctrl[trap_pkg::CTRL_MMU_BIT];
  assign user_any = (mode == trap_pkg::mode_user0) | (mode == trap_pkg::mode_user1);
  assign user0    = (mode == trap_pkg::mode_user0);
  assign rd_op    = instr.is_load | instr.is_load_modify_store_instruction | instr.is_swap;
  assign wr_op    = instr.is_store | instr.is_load_modify_store_instruction | instr.is_swap;
  assign mem_op   = rd_op | wr_op;

  assign c_ex     = mpu_on & ~|(xhit & perm[trap_pkg::PERM_EX_LSB +: trap_pkg::NUM_RANGES]);
  assign c_privilege_violation_trap   = (user_any & (instr.is_core_wr | instr.is_ctx_save))
                  | (user0 & instr.is_en_dis)
                  | (user_any & instr.is_tlb_op);
  assign c_fill   = mmu_on & mem_op & tlb_miss;
  assign c_pgprot = mmu_on & mem_op & ~tlb_miss & page_perm_fail;
  assign c_null   = mem_op & (instr.ea == 32'h0000_0000);
  assign c_periph = user0 & mem_op & is_periph_seg(instr.ea);
  assign c_rd     = mpu_on & rd_op & ~|(dhit & perm[trap_pkg::PERM_RD_LSB +: trap_pkg::NUM_RANGES]);
  assign c_wr     = mpu_on & wr_op & ~|(dhit & perm[trap_pkg::PERM_WR_LSB +: trap_pkg::NUM_RANGES]);
  assign c_global_register_write_trap   = instr.wr_global & ~global_wr_perm & is_prot_greg(instr.global_idx);

  // ==========================================
  // fixed priority: fetch first, then decode, translation, data
  logic       sel_hit;
  logic [2:0] sel_cls;
  logic [7:0] sel_tin;

  always_comb begin
    sel_hit = 1'h1;
    sel_cls = trap_pkg::CLASS_PROT;
    sel_tin = trap_pkg::TIN_RANGE_EX;
    if (c_ex) begin
      sel_tin = trap_pkg::TIN_RANGE_EX;
    end else if (c_privilege_violation_trap) begin
      sel_tin = trap_pkg::TIN_PRIVILEGE_VIOLATION_TRAP;
    end else if (c_fill) begin
      sel_cls = trap_pkg::CLASS_MMU;
      sel_tin = trap_pkg::TIN_PAGE_FILL;
    end else if (c_pgprot) begin
      sel_cls = trap_pkg::CLASS_MMU;
      sel_tin = trap_pkg::TIN_PAGE_PROT;
    end else if (c_null) begin
      sel_tin = trap_pkg::TIN_NULL;
    end else if (c_periph) begin
      sel_tin = trap_pkg::TIN_PERIPH;
    end else if (c_rd) begin
      sel_tin = trap_pkg::TIN_RANGE_RD;
    end else if (c_wr) begin
      sel_tin = trap_pkg::TIN_RANGE_WR;
    end else if (c_global_register_write_trap) begin
      sel_tin = trap_pkg::TIN_GLOBAL_WR;
    end else if (instr.is_system_call_instruction) begin
      // identifier straight from the 8-bit immediate, 0..255
      sel_cls = trap_pkg::CLASS_SYSTEM_CALL_INSTRUCTION;
      sel_tin = instr.system_call_instruction_imm;
    end else begin
      sel_hit = 1'h0;
    end
  end

  // ==========================================
  // take decision
  // sync wins the cycle; an async request waits until a cycle with no sync take
  logic        sync_take;
  logic        async_take;
  logic [31:0] async_ret;     // next pc to run had the trap not come

  assign sync_take  = instr.valid & sel_hit;
  // no enable or priority input gates this path
  assign async_take = async_req.valid & ~sync_take;
  assign async_ret  = instr.valid ? instr.next_pc : instr.pc;
  assign sync_flush = sync_take;   // kills the instruction before it retires
  assign async_ack  = async_take;

  // ==========================================
  // entry record, one-cycle valid
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      entry <= '0;
    end else begin
      entry.valid <= sync_take | async_take;
      if (sync_take | async_take) begin
        // priority number is owned elsewhere and never written here
        entry.is_sync  <= sync_take;
        entry.cls      <= sync_take ? sel_cls : async_req.cls;
        entry.trap_identifier_number      <= sync_take ? sel_tin : async_req.trap_identifier_number;
        entry.vector   <= trap_table_base |
                          (32'(sync_take ? sel_cls : async_req.cls) << trap_pkg::VEC_SHIFT);
        entry.ret_pc   <= sync_take ? instr.pc : async_ret;
        entry.perm_all <= 1'h1;
        entry.prs      <= trap_pkg::PRS_INTERRUPT_MAP;
        entry.stack_is <= 1'h1;
        entry.cdc      <= trap_pkg::CDC_ENTRY_64;
      end
    end
  end

  // implicit data register load, same cycle as the redirect
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      d15_we   <= 1'h0;
      d15_data <= 32'h0000_0000;
    end else begin
      d15_we <= sync_take | async_take;
      if (sync_take | async_take) begin
        d15_data <= 32'(sync_take ? sel_tin : async_req.trap_identifier_number);
      end
    end
  end

  // interrupt enable: a trap clears it and beats a same-cycle enable
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      int_enable <= 1'h0;
    end else if (sync_take | async_take) begin
      int_enable <= 1'h0;
    end else if (ie_set) begin
      int_enable <= 1'h1;
    end else if (ie_clr) begin
      int_enable <= 1'h0;
    end
  end

  // trap counter, wraps
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      trap_count <= 32'h0000_0000;
    end else if (sync_take | async_take) begin
      trap_count <= trap_count + 32'h0000_0001;
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_any_take;
    sync_take || async_take;
  endsequence

  sequence s_entry_forced;
    entry.valid && entry.perm_all && entry.stack_is &&
    entry.prs == trap_pkg::PRS_INTERRUPT_MAP && entry.cdc == trap_pkg::CDC_ENTRY_64;
  endsequence

  a_sync_ret_pc: assert property (sync_take |=> entry.ret_pc == $past(instr.pc) && entry.is_sync)
    else $error("sync return pc wrong");
  a_async_ret_pc: assert property (async_take |=> entry.ret_pc == $past(async_ret) && !entry.is_sync)
    else $error("async return pc wrong");
  a_entry_vector: assert property (s_any_take |=>
      entry.vector == ($past(trap_table_base) | (32'(entry.cls) << trap_pkg::VEC_SHIFT)))
    else $error("handler entry address wrong");
  a_entry_state: assert property (s_any_take |=> s_entry_forced)
    else $error("forced entry state wrong");
  a_d15_load: assert property (entry.valid |-> d15_we && d15_data == 32'(entry.trap_identifier_number))
    else $error("identifier not loaded");
  a_ie_off: assert property (s_any_take |=> !int_enable)
    else $error("interrupts left enabled");
  a_no_mmu_class: assert property (sync_take && !mmu_on |-> sel_cls != trap_pkg::CLASS_MMU)
    else $error("class zero without translation");
  a_null_taken: assert property (instr.valid && c_null && !c_ex && !c_privilege_violation_trap && !c_fill && !c_pgprot
      |=> entry.valid && entry.trap_identifier_number == trap_pkg::TIN_NULL)
    else $error("null address trap missed");
  a_async_unmask: assert property (async_req.valid && !sync_take |-> async_ack ##1 entry.valid)
    else $error("async trap not taken");
  a_one_trap: assert property (sync_take |-> !async_ack ##1 entry.cls == $past(sel_cls))
    else $error("more than one trap taken");

endmodule

// ==== pipe_model.sv ====
/*
  pipeline stand-in: presents one instruction a cycle to the trap unit.
  assumes the bench holds an idle instruction with the fetch pc between ops.
*/
`timescale 1ns/1ns
module pipe_model (
  // clock
  input  wire logic             mclk,
  // command from bench
  input  wire trap_pkg::instr_t cmd,
  // to trap unit
  output trap_pkg::instr_t      instr
);
  // one register stage, like a real retire slot
  always_ff @(posedge mclk) begin
    instr <= cmd;
  end
endmodule

// ==== cpu_trap_unit_tb_top.sv ====
/*
  bench for the trap unit: trap table, page, range and async entry.
  assumes pipe_model delays each command by one cycle.
*/
`timescale 1ns/1ns
module cpu_trap_unit_tb_top;
  // ==========================================
  // signals
  logic              mclk, rst_b, global_wr_perm, ie_set, ie_clr, tlb_miss, page_perm_fail;
  logic              av_waitrequest, sync_flush, async_ack, d15_we, int_enable;
  logic [31:0]       av_readdata, d15_data, q;
  trap_pkg::av_req_t av;
  trap_pkg::instr_t  cmd, instr, idle;
  trap_pkg::mode_t   mode;
  trap_pkg::async_t  async_req;
  trap_pkg::entry_t  entry;
  int                fail_count, compares, cyc;
  localparam logic [31:0] BASE = 32'h0000_1000; // trap table base
  localparam logic [31:0] PC   = 32'h0000_0200; // pc inside range 0

  cpu_trap_unit u_cpu_trap_unit (.mclk, .rst_b, .av, .av_readdata, .av_waitrequest, .instr, .mode,
    .global_wr_perm, .ie_set, .ie_clr, .sync_flush, .async_req, .async_ack, .tlb_miss, .page_perm_fail,
    .entry, .d15_we, .d15_data, .int_enable);
  pipe_model u_pipe_model (.mclk, .cmd, .instr);

  // ==========================================
  // clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      test_done();
    end
  end

  // ==========================================
  // helpers
  task automatic test_done();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // avalon cycle: hold until waitrequest is sampled low at a rising edge, take data and release there
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    av <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hF};
    do @(posedge mclk); while (av_waitrequest !== 1'b0);
    q = av_readdata;
    av <= '0;
  endtask
  // flags: {wr_global, system_call_instruction, core_wr, store, load}
  function automatic trap_pkg::instr_t mk(input logic [31:0] pc, input logic [31:0] ea, input logic [4:0] f);
    mk = idle;
    mk.valid = 1'b1;
    mk.pc = pc;
    mk.next_pc = pc + 32'h0000_0004;
    mk.ea = ea;
    {mk.wr_global, mk.is_system_call_instruction, mk.is_core_wr, mk.is_store, mk.is_load} = f;
    mk.system_call_instruction_imm = 8'hFF;
    mk.global_idx = 4'h8;
  endfunction
  // entry pulse check; ct is {class, identifier}
  task automatic take(input logic [10:0] ct, input logic [31:0] ret, input logic s);
    @(negedge mclk);
    chk("valid", entry.valid, 1'b1);
    chk("id", {entry.cls, entry.trap_identifier_number}, ct);
    chk("vector", entry.vector, BASE | {ct[10:8], 5'h00});
    chk("ret", entry.ret_pc, ret);
    chk("sync", entry.is_sync, s);
    chk("d15", d15_data, {24'h00_0000, ct[7:0]});
    chk("state", {d15_we, entry.perm_all, entry.prs, entry.stack_is, entry.cdc, int_enable}, 13'h1900);
  endtask
  task automatic run(input trap_pkg::instr_t c, input logic [1:0] tp, input logic [10:0] ct);
    @(posedge mclk);
    cmd <= c;
    @(posedge mclk);
    cmd <= idle;
    {tlb_miss, page_perm_fail} <= tp;
    @(negedge mclk);
    chk("flush", sync_flush, 1'b1);
    @(posedge mclk);
    {tlb_miss, page_perm_fail} <= 2'b00;
    take(ct, c.pc, 1'b1);
  endtask

  // ==========================================
  // scenarios
  task automatic t_table();
    run(mk(PC, 32'h0, 5'h01), 2'b00, 11'h106);
    @(posedge mclk);
    mode <= trap_pkg::mode_user0;
    run(mk(PC, 32'h0, 5'h05), 2'b00, 11'h101);
    @(posedge mclk);
    mode <= trap_pkg::mode_supervisor;
    run(mk(PC, 32'h0000_0010, 5'h08), 2'b00, 11'h6FF);
    $display("table test done");
  endtask
  task automatic t_page();
    bus(1'b1, trap_pkg::REG_CTRL, 32'h0000_0002);
    run(mk(PC, 32'h0000_0100, 5'h01), 2'b10, 11'h000);
    run(mk(PC, 32'h0000_0100, 5'h02), 2'b01, 11'h001);
    bus(1'b1, trap_pkg::REG_CTRL, 32'h0000_0000);
    $display("page test done");
  endtask
  task automatic t_range();
    bus(1'b1, trap_pkg::REG_RANGE_BASE, 32'h0000_0000);
    bus(1'b1, trap_pkg::REG_RANGE_BASE | 8'h04, 32'h1000_0000);
    bus(1'b1, trap_pkg::REG_PERM, 32'h0000_0111);
    bus(1'b1, trap_pkg::REG_CTRL, 32'h0000_0001);
    run(mk(PC, 32'h2000_0000, 5'h01), 2'b00, 11'h102);
    run(mk(PC, 32'h2000_0000, 5'h02), 2'b00, 11'h103);
    run(mk(32'h3000_0000, 32'h0000_0100, 5'h00), 2'b00, 11'h104);
    @(posedge mclk);
    mode <= trap_pkg::mode_user0;
    run(mk(PC, 32'hE000_0000, 5'h01), 2'b00, 11'h105);
    @(posedge mclk);
    mode <= trap_pkg::mode_supervisor;
    run(mk(PC, 32'h0, 5'h10), 2'b00, 11'h107);
    bus(1'b0, trap_pkg::REG_STATUS, 32'h0);
    chk("status", q, 32'h0001_0701);
    bus(1'b0, trap_pkg::REG_RET_PC, 32'h0);
    chk("ret pc reg", q, PC);
    // ten instructions trapped so far, one entry each
    bus(1'b0, trap_pkg::REG_COUNT, 32'h0);
    chk("count", q, 32'h0000_000A);
    bus(1'b0, 8'h80, 32'h0);
    chk("unmapped", q, 32'h0000_0000);
    $display("range test done");
  endtask
  task automatic t_async();
    @(posedge mclk);
    async_req <= '{valid: 1'b1, cls: 3'h7, trap_identifier_number: 8'h00};
    do @(posedge mclk); while (async_ack !== 1'b1);
    async_req <= '0;
    take(11'h700, idle.pc, 1'b0);
    repeat (3) @(posedge mclk);
    ie_set <= 1'b1;
    @(posedge mclk);
    ie_set <= 1'b0;
    @(negedge mclk);
    chk("ie on", int_enable, 1'b1);
    @(posedge mclk);
    ie_clr <= 1'b1;
    @(posedge mclk);
    ie_clr <= 1'b0;
    @(negedge mclk);
    chk("ie off", int_enable, 1'b0);
    $display("async test done");
  endtask

  // ==========================================
  // main sequence
  initial begin
    idle = '0;
    idle.pc = 32'h0000_0100;
    idle.next_pc = 32'h0000_0104;
    cmd = idle;
    av = '0;
    async_req = '0;
    mode = trap_pkg::mode_supervisor;
    {rst_b, global_wr_perm, ie_set, ie_clr, tlb_miss, page_perm_fail} = '0;
    fail_count = 0;
    compares = 0;
    cyc = 0;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    bus(1'b1, trap_pkg::REG_TRAP_BASE, BASE);
    t_table();
    t_page();
    t_range();
    t_async();
    test_done();
  end
endmodule
